// ===== rtl/tccu_top.sv
// tccu_top: capture/compare/pwm unit with its sixteen-bit timer, wishbone slave
// assumes classic wishbone master, one clock, pin synchronous to clk_i
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "tccu_params.svh"
module tccu_top import tccu_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic cap_pin_i,
   output logic cmp_pin_o,
   output logic irq_o
);
   tccu_link_if lnk ();

   tccu_edge u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lnk(lnk)
   );

   tccu_irq u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lnk(lnk)
   );

   function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] idx);
      return w & (a == idx);
   endfunction : wr_at

   logic [5:0] ctl1_q, ctl1_d;
   logic [5:0] ctl2_q, ctl2_d;
   logic [7:0] ien_a_q, ien_a_d;
   logic [7:0] ien_b_q, ien_b_d;
   logic [15:0] tmr_q, tmr_d;
   logic [15:0] cap_q, cap_d;
   logic run_q, run_d;
   logic out_q, out_d;
   logic eq_q, eq_d;
   logic ack_q, ack_d;
   logic [7:0] rdat_q, rdat_d;
   logic [3:0] mode;
   logic req, wr, match, trig, cap_evt, ovf, pwm_lvl;
   logic [7:0] wbyte;
   logic [7:0] adr;
   logic [9:0] duty;

   assign mode = ctl1_q[3:0];
   assign lnk.mode = mode;
   assign lnk.pin = cap_pin_i;
   assign adr = wb_adr_i;

   // wishbone: ack one cycle after the request, write lands on the ack edge
   always_comb begin
      req = wb_cyc_i & wb_stb_i;
      wr = req & wb_we_i & ack_q & wb_sel_i[0];
      wbyte = wb_dat_i[7:0];
      ack_d = req & ~ack_q;
      rdat_d = 8'h00;
      if (req & ~ack_q & ~wb_we_i) begin
         case (adr)
            `TCCU_IDX_CTL1: rdat_d = {2'b00, ctl1_q};
            `TCCU_IDX_CTL2: rdat_d = {2'b00, ctl2_q};
            `TCCU_IDX_IEN_A: rdat_d = ien_a_q;
            `TCCU_IDX_IEN_B: rdat_d = ien_b_q;
            `TCCU_IDX_FLAGS: rdat_d = lnk.flags;
            `TCCU_IDX_TMR_LO: rdat_d = tmr_q[7:0];
            `TCCU_IDX_TMR_HI: rdat_d = tmr_q[15:8];
            `TCCU_IDX_CAP_LO: rdat_d = cap_q[7:0];
            `TCCU_IDX_CAP_HI: rdat_d = cap_q[15:8];
            `TCCU_IDX_TMR_CTL: rdat_d = {7'h00, run_q};
            default: rdat_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= `TCCU_RST_BYTE;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = {24'h000000, rdat_q};

   // control and enable registers
   always_comb begin
      ctl1_d = ctl1_q;
      ctl2_d = ctl2_q;
      ien_a_d = ien_a_q;
      ien_b_d = ien_b_q;
      // mode nibble and duty low bits written together
      if (wr_at(wr, adr, `TCCU_IDX_CTL1)) begin
         ctl1_d = wbyte[5:0];
      end
      if (wr_at(wr, adr, `TCCU_IDX_CTL2)) begin
         ctl2_d = wbyte[5:0];
      end
      if (wr_at(wr, adr, `TCCU_IDX_IEN_A)) begin
         ien_a_d = wbyte;
      end
      if (wr_at(wr, adr, `TCCU_IDX_IEN_B)) begin
         ien_b_d = wbyte;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl1_q <= `TCCU_RST_CTL;
         ctl2_q <= `TCCU_RST_CTL;
         ien_a_q <= `TCCU_RST_BYTE;
         ien_b_q <= `TCCU_RST_BYTE;
      end else begin
         ctl1_q <= ctl1_d;
         ctl2_q <= ctl2_d;
         ien_a_q <= ien_a_d;
         ien_b_q <= ien_b_d;
      end
   end

   // timer, capture/compare register, output pin, flag events
   always_comb begin
      eq_d = tmr_q == cap_q;
      // one match per arrival, not every cycle a stopped timer sits equal
      match = is_compare(mode) & eq_d & ~eq_q;
      trig = match & (mode == CMP_TRIG);
      cap_evt = is_capture(mode) & lnk.evt;
      duty = {cap_q[7:0], ctl1_q[5:4]};
      pwm_lvl = tmr_q[9:0] < duty;
      ovf = run_q & (tmr_q == 16'hFFFF);
      run_d = run_q;
      tmr_d = tmr_q;
      cap_d = cap_q;
      out_d = out_q;
      if (wr_at(wr, adr, `TCCU_IDX_TMR_CTL)) begin
         run_d = wbyte[`TCCU_BIT_TMR_RUN];
      end
      if (trig) begin
         tmr_d = `TCCU_RST_WORD;
      end else if (wr_at(wr, adr, `TCCU_IDX_TMR_LO)) begin
         tmr_d[7:0] = wbyte;
      end else if (wr_at(wr, adr, `TCCU_IDX_TMR_HI)) begin
         tmr_d[15:8] = wbyte;
      end else if (run_q) begin
         tmr_d = tmr_q + 16'h0001;
      end
      // a capture beats a software write; unread values are simply lost
      if (cap_evt) begin
         cap_d = tmr_q;
      end else if (wr_at(wr, adr, `TCCU_IDX_CAP_LO)) begin
         cap_d[7:0] = wbyte;
      end else if (wr_at(wr, adr, `TCCU_IDX_CAP_HI)) begin
         cap_d[15:8] = wbyte;
      end
      case (mode)
         TCCU_OFF: out_d = 1'b0;
         CMP_SET: begin
            if (match) begin
               out_d = 1'b1;
            end
         end
         CMP_CLR: begin
            if (match) begin
               out_d = 1'b0;
            end
         end
         CMP_FLAG: ;
         CMP_TRIG: ;
         default: begin
            // reserved codes and capture modes leave the pin alone
            if (is_pwm(mode)) begin
               out_d = pwm_lvl;
            end
         end
      endcase
      lnk.set = 8'h00;
      lnk.set[`TCCU_BIT_CAP_FLAG] = cap_evt | match;
      lnk.set[`TCCU_BIT_TMR_OVF] = ovf;
      lnk.clr = wr_at(wr, adr, `TCCU_IDX_FLAG_CLR) ? wbyte : 8'h00;
      lnk.en = ien_a_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
         tmr_q <= `TCCU_RST_WORD;
         cap_q <= `TCCU_RST_WORD;
         out_q <= 1'b0;
         eq_q <= 1'b0;
      end else begin
         run_q <= run_d;
         tmr_q <= tmr_d;
         cap_q <= cap_d;
         out_q <= out_d;
         eq_q <= eq_d;
      end
   end

   assign cmp_pin_o = out_q;
   assign irq_o = lnk.irq;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_capture_copy: assert property (cap_evt |=> cap_q == $past(tmr_q))
      else $error("capture did not store the timer value");
   chk_capture_flag: assert property (cap_evt |=> lnk.flags[2])
      else $error("capture did not set the capture flag");
   chk_capture_overwrite: assert property (cap_evt && (cap_q != tmr_q) |=> cap_q != $past(cap_q))
      else $error("second capture did not replace the first");
   chk_cmp_drive_high: assert property (match && mode == CMP_SET |=> cmp_pin_o)
      else $error("compare set mode left the pin low");
   chk_cmp_drive_low: assert property (match && mode == CMP_CLR |=> !cmp_pin_o ##0 lnk.flags[2])
      else $error("compare clear mode wrong pin or flag");
   chk_cmp_pin_kept: assert property (mode == CMP_FLAG |=> cmp_pin_o == $past(cmp_pin_o))
      else $error("flag-only compare moved the pin");
   chk_special_reset: assert property (trig |=> tmr_q == 16'h0000 ##0 lnk.flags[2])
      else $error("special event did not reset the timer");
   chk_pwm_duty: assert property (is_pwm(mode) |=> cmp_pin_o == $past(pwm_lvl))
      else $error("pwm level does not follow duty");
   chk_off_pin_low: assert property (mode == TCCU_OFF |=> !cmp_pin_o)
      else $error("pin not low with unit off");

   cov_capture: cover property (cap_evt ##1 lnk.flags[2]);
   cov_special: cover property (trig ##1 tmr_q == 16'h0000);
   cov_irq: cover property (!irq_o ##1 irq_o);
   cov_pwm: cover property (is_pwm(mode) && cmp_pin_o);
endmodule : tccu_top

// ===== shared/tccu_params.svh
// tccu_params.svh: register indices, field positions, reset values, counts
// assumes byte address = 4 * index on the wishbone bus
`ifndef TCCU_PARAMS_SVH
`define TCCU_PARAMS_SVH
// register indices
`define TCCU_IDX_CTL1 8'h17
`define TCCU_IDX_CTL2 8'h1D
`define TCCU_IDX_IEN_A 8'h8C
`define TCCU_IDX_IEN_B 8'h8D
`define TCCU_IDX_FLAGS 8'h0C
`define TCCU_IDX_FLAG_CLR 8'h40
`define TCCU_IDX_TMR_LO 8'h41
`define TCCU_IDX_TMR_HI 8'h42
`define TCCU_IDX_CAP_LO 8'h43
`define TCCU_IDX_CAP_HI 8'h44
`define TCCU_IDX_TMR_CTL 8'h45
// field positions
`define TCCU_BIT_CAP_FLAG 2
`define TCCU_BIT_TMR_OVF 0
`define TCCU_BIT_TMR_RUN 0
`define TCCU_CTL_DUTY_LSB 4
// reset values
`define TCCU_RST_CTL 6'h00
`define TCCU_RST_BYTE 8'h00
`define TCCU_RST_WORD 16'h0000
// prescaler terminal counts
`define TCCU_PRE4_LAST 4'h3
`define TCCU_PRE16_LAST 4'hF
`endif

// ===== shared/tccu_pkg.sv
// tccu_pkg: mode codes and mode decoding shared by the unit's modules
// assumes the four-bit mode field of the unit control register
package tccu_pkg;
   typedef enum logic [3:0] {
      TCCU_OFF = 4'h0,
      CAP_FALL = 4'h4,
      CAP_RISE = 4'h5,
      CAP_RISE4 = 4'h6,
      CAP_RISE16 = 4'h7,
      CMP_SET = 4'h8,
      CMP_CLR = 4'h9,
      CMP_FLAG = 4'hA,
      CMP_TRIG = 4'hB
   } tccu_mode_t;

   function automatic logic is_capture(input logic [3:0] m);
      return m[3:2] == 2'b01;
   endfunction : is_capture

   function automatic logic is_compare(input logic [3:0] m);
      return m[3:2] == 2'b10;
   endfunction : is_compare

   function automatic logic is_pwm(input logic [3:0] m);
      return m[3:2] == 2'b11;
   endfunction : is_pwm
endpackage : tccu_pkg

// ===== shared/tccu_link_if.sv
// tccu_link_if: signals between the unit core, edge detector and flag block
// assumes all three sit on one clock
`timescale 1ns/100ps
interface tccu_link_if;
   logic [3:0] mode;
   logic pin;
   logic evt;
   logic [7:0] set;
   logic [7:0] clr;
   logic [7:0] en;
   logic [7:0] flags;
   logic irq;
   modport edge_mp (input mode, input pin, output evt);
   modport irq_mp (input set, input clr, input en, output flags, output irq);
   modport core_mp (output mode, output pin, output set, output clr, output en,
                    input evt, input flags, input irq);
endinterface : tccu_link_if

// ===== rtl/tccu_edge.sv
// tccu_edge: pin edge detection and rising-edge prescaler
// assumes the pin level is synchronous to clk_i
`timescale 1ns/100ps
`include "tccu_params.svh"
module tccu_edge import tccu_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link to core
   tccu_link_if.edge_mp lnk
);
   logic prev_q, prev_d;
   logic [3:0] cnt_q, cnt_d;
   logic rise, fall, hit;

   always_comb begin
      // pin level only, direction unknown here: port writes count too
      rise = lnk.pin & ~prev_q;
      fall = ~lnk.pin & prev_q;
      prev_d = lnk.pin;
      cnt_d = cnt_q;
      hit = 1'b0;
      case (lnk.mode)
         TCCU_OFF: cnt_d = 4'h0;
         CAP_FALL: hit = fall;
         CAP_RISE: hit = rise;
         CAP_RISE4: begin
            // count survives a mode change, so a switch may fire early
            if (rise) begin
               hit = cnt_q >= `TCCU_PRE4_LAST;
               cnt_d = hit ? 4'h0 : cnt_q + 4'h1;
            end
         end
         CAP_RISE16: begin
            if (rise) begin
               hit = cnt_q >= `TCCU_PRE16_LAST;
               cnt_d = hit ? 4'h0 : cnt_q + 4'h1;
            end
         end
         default: ;
      endcase
      lnk.evt = hit;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         prev_q <= prev_d;
         cnt_q <= cnt_d;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_rise_fires: assert property ((lnk.mode == CAP_RISE) && rise |-> lnk.evt)
      else $error("rising edge in rise mode gave no event");
   // a count left over from sixteenth mode may exceed three: spurious but legal
   chk_fourth_count: assert property ((lnk.mode == CAP_RISE4) && lnk.evt
      |-> cnt_q >= `TCCU_PRE4_LAST ##1 cnt_q == 4'h0)
      else $error("fourth-edge event below terminal count");
   // only the off cycle itself is event-free; the next cycle may already hold a new mode
   chk_off_clears: assert property (lnk.mode == TCCU_OFF |-> !lnk.evt ##1 cnt_q == 4'h0)
      else $error("prescaler not cleared when unit off");
endmodule : tccu_edge

// ===== rtl/tccu_irq.sv
// tccu_irq: sticky event flags, enable gating and the level interrupt
// assumes set and clr are one-cycle pulses from the core
`timescale 1ns/100ps
module tccu_irq (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link to core
   tccu_link_if.irq_mp lnk
);
   logic [7:0] flags_q, flags_d;
   logic irq_q, irq_d;

   for (genvar i = 0; i < 8; i++) begin : g_flag
      // set beats a clear in the same cycle
      assign flags_d[i] = lnk.set[i] | (flags_q[i] & ~lnk.clr[i]);
   end

   always_comb begin
      irq_d = |(flags_d & lnk.en);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         irq_q <= irq_d;
      end
   end

   assign lnk.flags = flags_q;
   assign lnk.irq = irq_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_flag_sticky: assert property (lnk.flags[2] && !lnk.clr[2] |=> lnk.flags[2])
      else $error("capture flag dropped without a clear");
   chk_irq_level: assert property (lnk.irq == |(lnk.flags & $past(lnk.en)))
      else $error("interrupt level does not match enabled flags");
endmodule : tccu_irq

// ===== bench/tccu_pin_model.sv
// tccu_pin_model: external event source on the capture pin
// assumes the bench calls pulses() right after a rising clk_i edge
`timescale 1ns/100ps
module tccu_pin_model (
   // clock
   input wire logic clk_i,
   // capture pin
   output logic pin_o
);
   // idle low so the detector's reset history sees no edge
   initial begin
      pin_o = 1'b0;
   end

   // n pulses, hi cycles high and two low; levels change only at edges
   task automatic pulses(input int n, input int hi);
      repeat (n) begin
         pin_o <= 1'b1;
         repeat (hi) @(posedge clk_i);
         pin_o <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask : pulses
endmodule : tccu_pin_model

// ===== bench/tb.sv
// tb: register-level tests of the capture/compare/pwm unit
// assumes classic wishbone timing and the pin model as event source
`timescale 1ns/100ps
`include "tccu_params.svh"
module tb import tccu_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [9:2] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic cmp_pin_o;
   logic irq_o;
   logic cap_pin;
   logic [31:0] rd;
   int num_errors = 0;
   int tests_run = 0;
   logic [3:0] cm [3] = '{CMP_SET, CMP_FLAG, CMP_CLR};
   logic [7:0] pc [4] = '{8'h1C, 8'h0C, 8'h0C, 8'h2C};
   logic [7:0] pd [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
   logic [15:0] pt [4] = '{16'h0000, 16'h0000, 16'h0003, 16'h0001};
   logic pe [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

   tccu_top tccu_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_pin_i(cap_pin), .cmp_pin_o(cmp_pin_o), .irq_o(irq_o));
   tccu_pin_model tccu_pin_model_i (.clk_i(clk_i), .pin_o(cap_pin));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // values seen at the edge are pre-update, so ack and data are taken together
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= idx;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, wd};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      xfer(1'b1, idx, wd);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask : rdc

   task automatic set_tmr(input logic [15:0] v);
      wr(`TCCU_IDX_TMR_CTL, 8'h00);
      wr(`TCCU_IDX_TMR_LO, v[7:0]);
      wr(`TCCU_IDX_TMR_HI, v[15:8]);
   endtask : set_tmr

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(`TCCU_IDX_CTL1, 32'h0);
      rdc(`TCCU_IDX_IEN_A, 32'h0);
      rdc(8'h50, 32'h0);
      wr(`TCCU_IDX_CTL2, 8'hFF);
      rdc(`TCCU_IDX_CTL2, 32'h3F);
      wr(`TCCU_IDX_IEN_B, 8'hA5);
      rdc(`TCCU_IDX_IEN_B, 32'hA5);
      $display("test reset done");
      wr(`TCCU_IDX_IEN_A, 8'h04);
      set_tmr(16'hA534);
      wr(`TCCU_IDX_CTL1, {4'h0, CAP_RISE});
      wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
      tccu_pin_model_i.pulses(1, 2);
      rdc(`TCCU_IDX_CAP_LO, 32'h34);
      rdc(`TCCU_IDX_CAP_HI, 32'hA5);
      repeat (20) @(posedge clk_i);
      rdc(`TCCU_IDX_FLAGS, 32'h04);
      chk(irq_o, 1'b1);
      set_tmr(16'h5A11);
      tccu_pin_model_i.pulses(1, 2);
      rdc(`TCCU_IDX_CAP_HI, 32'h5A);
      wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
      rdc(`TCCU_IDX_FLAGS, 32'h0);
      chk(irq_o, 1'b0);
      $display("test rising capture done");
      // masked: flag still sets, irq stays low
      wr(`TCCU_IDX_IEN_A, 8'h00);
      wr(`TCCU_IDX_CTL1, {4'h0, CAP_FALL});
      wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
      fork
         tccu_pin_model_i.pulses(1, 20);
         begin
            do @(posedge clk_i); while (cap_pin !== 1'b1);
            rdc(`TCCU_IDX_FLAGS, 32'h0);
         end
      join
      rdc(`TCCU_IDX_FLAGS, 32'h04);
      chk(irq_o, 1'b0);
      $display("test falling capture done");
      // leftover prescaler count must be wiped by the off code
      for (int k = 0; k < 2; k++) begin
         wr(`TCCU_IDX_CTL1, {4'h0, (k == 0) ? CAP_RISE4 : CAP_RISE16});
         tccu_pin_model_i.pulses(2, 2);
         wr(`TCCU_IDX_CTL1, {4'h0, TCCU_OFF});
         wr(`TCCU_IDX_CTL1, {4'h0, (k == 0) ? CAP_RISE4 : CAP_RISE16});
         wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
         tccu_pin_model_i.pulses((k == 0) ? 3 : 15, 2);
         rdc(`TCCU_IDX_FLAGS, 32'h0);
         tccu_pin_model_i.pulses(1, 2);
         rdc(`TCCU_IDX_FLAGS, 32'h04);
      end
      $display("test prescaler done");
      wr(`TCCU_IDX_CAP_LO, 8'h10);
      wr(`TCCU_IDX_CAP_HI, 8'h00);
      for (int k = 0; k < 3; k++) begin
         set_tmr(16'h0000);
         wr(`TCCU_IDX_CTL1, {4'h0, cm[k]});
         wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
         wr(`TCCU_IDX_TMR_CTL, 8'h01);
         repeat (40) @(posedge clk_i);
         chk(cmp_pin_o, (k == 2) ? 1'b0 : 1'b1);
         rdc(`TCCU_IDX_FLAGS, 32'h04);
      end
      set_tmr(16'h0000);
      wr(`TCCU_IDX_CTL1, {4'h0, CMP_TRIG});
      wr(`TCCU_IDX_TMR_CTL, 8'h01);
      repeat (100) @(posedge clk_i);
      wr(`TCCU_IDX_TMR_CTL, 8'h00);
      rdc(`TCCU_IDX_TMR_HI, 32'h0);
      xfer(1'b0, `TCCU_IDX_TMR_LO, 8'h00);
      chk(rd <= 32'h11, 1'b1);
      $display("test compare done");
      for (int k = 0; k < 4; k++) begin
         set_tmr(pt[k]);
         wr(`TCCU_IDX_CAP_LO, pd[k]);
         wr(`TCCU_IDX_CTL1, pc[k]);
         repeat (2) @(posedge clk_i);
         chk(cmp_pin_o, pe[k]);
      end
      rdc(`TCCU_IDX_CTL1, 32'h2C);
      $display("test pwm done");
      // overflow flag bit0 and its enable gate the level interrupt
      set_tmr(16'hFFFC);
      wr(`TCCU_IDX_FLAG_CLR, 8'hFF);
      wr(`TCCU_IDX_IEN_A, 8'h01);
      wr(`TCCU_IDX_TMR_CTL, 8'h01);
      repeat (5) @(posedge clk_i);
      rdc(`TCCU_IDX_TMR_CTL, 32'h01);
      rdc(`TCCU_IDX_FLAGS, 32'h01);
      chk(irq_o, 1'b1);
      $display("test overflow done");
      print_verdict();
   end
endmodule : tb
